// ===== clock_mode_pkg.sv
/*
 * Constants and carrier types for the clock, mode, oscillator monitor and
 * write-protect block. Assumes one 250 MHz system clock and software writes
 * arriving one at a time on a plain write port.
 */
// Overview of operation
// R1: sub and main oscillator run per stop bits
// R2: divider: div8 bit, else 1/2/4/16 by hi:lo
// R3: sub select bit picks sub clock for CPU
// R4: on-chip select, else PLL only if both set
// R5: stop entry bit or wait instruction enters mode
// R6: hardware interrupt leaves stop or wait
// R7: monitor active only while enable bit set
// R8: detection: reset if action 0, else interrupt
// R9: software keeps monitor off at 2 MHz or less
// R10: reset action stop halts until hardware reset
// R11: software avoids reset action enable while stopped
// R12: main source stop: irq, on-chip, set three bits
// R13: PLL source stop: irq, flags, select unchanged
// R14: resume: irq, detected set, halted cleared
// R15: irq shares watchdog vector, read detected bit
// R16: detected bit masks further irqs until cleared
// R17: low-speed stop: CPU stays sub, peripherals on-chip
// R18: software clears wait peripheral stop bit first
// R19: software disables monitor before main clock changes
// R20: three write-enables guard three register groups
// R21: third write-enable clears after next write
// R22: first two write-enables clear only by software
// R23: guarded writes ignored while enable is zero
// R24: stop exit forces divide-by-8 bit
// R25: writing main stop bit 1 forces divide-by-8
// R26: software disables monitor before mode transitions
package clock_mode_pkg;
    localparam real CLK_PERIOD_NS = 4.0;

    // register indices on the write/read port
    localparam logic [3:0] IDX_CLOCK_CTRL0   = 4'h0;
    localparam logic [3:0] IDX_CLOCK_CTRL1   = 4'h1;
    localparam logic [3:0] IDX_OSC_MON_CTRL  = 4'h2;
    localparam logic [3:0] IDX_PLL_CTRL      = 4'h3;
    localparam logic [3:0] IDX_PERIPH_CLK    = 4'h4;
    localparam logic [3:0] IDX_CAN_CLK       = 4'h5;
    localparam logic [3:0] IDX_PROC_MODE0    = 4'h6;
    localparam logic [3:0] IDX_PROC_MODE1    = 4'h7;
    localparam logic [3:0] IDX_PROC_MODE2    = 4'h8;
    localparam logic [3:0] IDX_TIMER_B2_SPEC = 4'h9;
    localparam logic [3:0] IDX_INVERTER0     = 4'ha;
    localparam logic [3:0] IDX_INVERTER1     = 4'hb;
    localparam logic [3:0] IDX_PORT7_DIR     = 4'hc;
    localparam logic [3:0] IDX_PORT9_DIR     = 4'hd;
    localparam logic [3:0] IDX_SERIAL3_CTRL  = 4'he;
    localparam logic [3:0] IDX_WRITE_PROTECT = 4'hf;

    // clock_ctrl_reg0 fields
    localparam int BIT_WAIT_PERIPH_STOP = 2;
    localparam int BIT_SUB_OSC_RUN      = 4;
    localparam int BIT_MAIN_OSC_STOP    = 5;
    localparam int BIT_CPU_DIV8_SEL     = 6;
    localparam int BIT_CPU_SRC_SUB_SEL  = 7;
    // clock_ctrl_reg1 fields
    localparam int BIT_STOP_MODE_ENTRY  = 0;
    localparam int BIT_PLL_SRC_SEL      = 1;
    localparam int BIT_CPU_DIV_SEL_LO   = 6;
    localparam int BIT_CPU_DIV_SEL_HI   = 7;
    // osc_monitor_ctrl_reg fields
    localparam int BIT_OSC_MON_EN       = 0;
    localparam int BIT_ONCHIP_SRC_SEL   = 1;
    localparam int BIT_OSC_CHANGE_DET   = 2;
    localparam int BIT_MAIN_CLK_HALTED  = 3;
    localparam int BIT_OSC_MON_ACTION   = 7;
    // pll_ctrl_reg fields
    localparam int BIT_PLL_ON           = 7;
    // write_protect_reg fields
    localparam int BIT_CLK_REG_WE       = 0;
    localparam int BIT_MODE_REG_WE      = 1;
    localparam int BIT_DIR_REG_WE       = 2;

    // values after reset
    localparam logic [7:0] RST_CLOCK_CTRL0 = 8'h40;
    localparam logic [7:0] RST_OTHER       = 8'h00;
    localparam logic       RST_OSC_ALIVE   = 1'b1;

    typedef enum logic [1:0] {
        SRC_MAIN,
        SRC_PLL,
        SRC_ONCHIP,
        SRC_SUB
    } cpu_src_t;

    typedef enum logic [1:0] {
        GRP_NONE,
        GRP_CLOCK,
        GRP_MODE,
        GRP_DIR
    } guard_grp_t;

    typedef struct packed {
        logic       en;
        logic [3:0] idx;
        logic [7:0] data;
    } sw_write_t;

    typedef struct packed {
        cpu_src_t cpu_src;
        logic [4:0] cpu_div;
        logic     sub_osc_run;
        logic     main_osc_run;
        logic     onchip_osc_run;
        logic     periph_on_onchip;
        logic     wait_periph_clk_stop;
    } clk_status_t;
endpackage

// ===== clock_mode_osc_monitor_protect.sv
/*
 * Clock selection, CPU divider, stop/wait mode control, main oscillator
 * stop/re-oscillation monitor and register write protection.
 * Assumes all inputs synchronous to sys_clk_in and at most one software
 * write per cycle; main_osc_alive_in is a level from an analog detector.
 */
`timescale 1ns/100ps
module clock_mode_osc_monitor_protect (
    input  wire logic                        sys_clk_in,
    input  wire logic                        rst_in,
    input  wire clock_mode_pkg::sw_write_t   sw_wr_in,
    input  wire logic [3:0]                  rd_idx_in,
    input  wire logic                        wait_instr_in,
    input  wire logic                        hw_irq_in,
    input  wire logic                        main_osc_alive_in,
    output logic [7:0]                       rd_data_out,
    output clock_mode_pkg::clk_status_t      clk_status_out,
    output logic                             stop_mode_out,
    output logic                             wait_mode_out,
    output logic                             osc_change_irq_out,
    output logic                             osc_stop_reset_out
);
    typedef enum logic [1:0] {
        MODE_RUN,
        MODE_STOP,
        MODE_WAIT
    } run_mode_t;

    logic [7:0] regs      [16];
    logic [7:0] next_regs [16];
    run_mode_t  mode;
    run_mode_t  next_mode;
    logic       osc_alive;
    logic       periph_fallback;
    logic       next_periph_fallback;
    logic       reset_halt;
    logic       next_reset_halt;
    logic       irq;
    logic       next_irq;
    logic [7:0] next_rd_data;

    function automatic clock_mode_pkg::guard_grp_t guard_of(input logic [3:0] idx);
        if (idx <= clock_mode_pkg::IDX_CAN_CLK) begin
            guard_of = clock_mode_pkg::GRP_CLOCK;
        end else if (idx <= clock_mode_pkg::IDX_INVERTER1) begin
            guard_of = clock_mode_pkg::GRP_MODE;
        end else if (idx <= clock_mode_pkg::IDX_SERIAL3_CTRL) begin
            guard_of = clock_mode_pkg::GRP_DIR;
        end else begin
            guard_of = clock_mode_pkg::GRP_NONE;
        end
    endfunction

    function automatic clock_mode_pkg::cpu_src_t src_of(input logic [7:0] cm0,
                                                        input logic [7:0] cm1,
                                                        input logic [7:0] cm2,
                                                        input logic [7:0] pll);
        if (cm0[clock_mode_pkg::BIT_CPU_SRC_SUB_SEL]) begin
            src_of = clock_mode_pkg::SRC_SUB;                                    // [R3]
        end else if (cm2[clock_mode_pkg::BIT_ONCHIP_SRC_SEL]) begin
            src_of = clock_mode_pkg::SRC_ONCHIP;                                 // [R4]
        end else if (pll[clock_mode_pkg::BIT_PLL_ON] && cm1[clock_mode_pkg::BIT_PLL_SRC_SEL]) begin
            src_of = clock_mode_pkg::SRC_PLL;                                    // [R4]
        end else begin
            src_of = clock_mode_pkg::SRC_MAIN;
        end
    endfunction

    function automatic logic [4:0] div_of(input logic [7:0] cm0, input logic [7:0] cm1);
        logic [1:0] sel;
        sel = {cm1[clock_mode_pkg::BIT_CPU_DIV_SEL_HI], cm1[clock_mode_pkg::BIT_CPU_DIV_SEL_LO]};
        if (cm0[clock_mode_pkg::BIT_CPU_DIV8_SEL]) begin
            div_of = 5'h08;                                                      // [R2]
        end else begin
            unique case (sel)
                2'h0: div_of = 5'h01;                                            // [R2]
                2'h1: div_of = 5'h02;
                2'h2: div_of = 5'h04;
                2'h3: div_of = 5'h10;
            endcase
        end
    endfunction

    always_comb begin
        logic                        we;
        logic [7:0]                  prot;
        clock_mode_pkg::cpu_src_t    src;
        logic                        stop_evt;
        logic                        reosc_evt;
        we        = 1'b0;
        prot      = regs[clock_mode_pkg::IDX_WRITE_PROTECT];
        src       = src_of(regs[0], regs[1], regs[2], regs[3]);
        stop_evt  = 1'b0;
        reosc_evt = 1'b0;
        next_regs = regs;
        next_mode = mode;
        next_irq  = 1'b0;
        next_periph_fallback = periph_fallback;
        next_reset_halt      = reset_halt;

        // software write, gated by its group's enable; the ungrouped write-protect register is always written
        if (sw_wr_in.en) begin
            unique case (guard_of(sw_wr_in.idx))
                clock_mode_pkg::GRP_CLOCK: we = prot[clock_mode_pkg::BIT_CLK_REG_WE];  // [R20] [R23]
                clock_mode_pkg::GRP_MODE:  we = prot[clock_mode_pkg::BIT_MODE_REG_WE]; // [R20] [R23]
                clock_mode_pkg::GRP_DIR:   we = prot[clock_mode_pkg::BIT_DIR_REG_WE];  // [R20] [R23]
                clock_mode_pkg::GRP_NONE:  we = 1'b1;
            endcase
            if (we) begin
                next_regs[sw_wr_in.idx] = sw_wr_in.data;
            end
            if (sw_wr_in.idx == clock_mode_pkg::IDX_WRITE_PROTECT) begin
                next_regs[clock_mode_pkg::IDX_WRITE_PROTECT] = {5'h00, sw_wr_in.data[2:0]}; // [R22]
            end else begin
                next_regs[clock_mode_pkg::IDX_WRITE_PROTECT][clock_mode_pkg::BIT_DIR_REG_WE] = 1'b0; // [R21]
            end
            if (we && sw_wr_in.idx == clock_mode_pkg::IDX_CLOCK_CTRL0
                   && sw_wr_in.data[clock_mode_pkg::BIT_MAIN_OSC_STOP]) begin
                next_regs[0][clock_mode_pkg::BIT_CPU_DIV8_SEL] = 1'b1;              // [R25]
            end
            if (we && sw_wr_in.idx == clock_mode_pkg::IDX_CLOCK_CTRL1
                   && sw_wr_in.data[clock_mode_pkg::BIT_STOP_MODE_ENTRY]) begin
                next_mode = MODE_STOP;                                           // [R5]
            end
        end

        // stop and wait modes
        if (mode == MODE_RUN && wait_instr_in && next_mode == MODE_RUN) begin
            next_mode = MODE_WAIT;                                               // [R5]
        end
        if (mode != MODE_RUN && hw_irq_in) begin
            next_mode = MODE_RUN;                                                // [R6]
            if (mode == MODE_STOP) begin
                next_regs[0][clock_mode_pkg::BIT_CPU_DIV8_SEL] = 1'b1;          // [R24]
                next_regs[1][clock_mode_pkg::BIT_STOP_MODE_ENTRY] = 1'b0;
            end
        end

        // oscillator monitor
        if (regs[2][clock_mode_pkg::BIT_OSC_MON_EN]) begin                       // [R7]
            stop_evt  = osc_alive && !main_osc_alive_in;
            reosc_evt = !osc_alive && main_osc_alive_in;
        end
        if (stop_evt || reosc_evt) begin
            if (!regs[2][clock_mode_pkg::BIT_OSC_MON_ACTION]) begin
                next_reset_halt = 1'b1;                                          // [R8] [R10]
            end else begin
                // hardware set wins over a same-cycle software clear
                next_irq = !regs[2][clock_mode_pkg::BIT_OSC_CHANGE_DET];         // [R8] [R16]
                next_regs[2][clock_mode_pkg::BIT_OSC_CHANGE_DET] = 1'b1;         // [R16]
                next_regs[2][clock_mode_pkg::BIT_MAIN_CLK_HALTED] = stop_evt;    // [R12] [R13] [R14]
                if (stop_evt && src == clock_mode_pkg::SRC_MAIN) begin
                    next_regs[2][clock_mode_pkg::BIT_ONCHIP_SRC_SEL] = 1'b1;     // [R12]
                end
                if (stop_evt && src == clock_mode_pkg::SRC_SUB) begin
                    next_periph_fallback = 1'b1;                                 // [R17]
                end
                if (reosc_evt) begin
                    next_periph_fallback = 1'b0;
                end
            end
        end
    end

    always_comb begin
        next_rd_data = regs[rd_idx_in];                                          // [R15]
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < 16; i++) begin
                regs[i] <= clock_mode_pkg::RST_OTHER;
            end
            regs[0]         <= clock_mode_pkg::RST_CLOCK_CTRL0;
            mode            <= MODE_RUN;
            osc_alive       <= clock_mode_pkg::RST_OSC_ALIVE;
            periph_fallback <= 1'b0;
            reset_halt      <= 1'b0;
            irq             <= 1'b0;
            rd_data_out     <= 8'h00;
        end else begin
            regs            <= next_regs;
            mode            <= next_mode;
            osc_alive       <= main_osc_alive_in;
            periph_fallback <= next_periph_fallback;
            reset_halt      <= next_reset_halt;
            irq             <= next_irq;
            rd_data_out     <= next_rd_data;
        end
    end

    always_comb begin
        clk_status_out.cpu_src      = src_of(regs[0], regs[1], regs[2], regs[3]);
        clk_status_out.cpu_div      = div_of(regs[0], regs[1]);
        clk_status_out.sub_osc_run  = regs[0][clock_mode_pkg::BIT_SUB_OSC_RUN];       // [R1]
        clk_status_out.main_osc_run = !regs[0][clock_mode_pkg::BIT_MAIN_OSC_STOP]     // [R1]
                                      && mode != MODE_STOP;
        clk_status_out.onchip_osc_run   = regs[2][clock_mode_pkg::BIT_ONCHIP_SRC_SEL]
                                          || periph_fallback;                          // [R12] [R17]
        clk_status_out.periph_on_onchip = regs[2][clock_mode_pkg::BIT_ONCHIP_SRC_SEL]
                                          || periph_fallback;                          // [R17]
        clk_status_out.wait_periph_clk_stop = regs[0][clock_mode_pkg::BIT_WAIT_PERIPH_STOP];
    end

    assign stop_mode_out      = (mode == MODE_STOP);
    assign wait_mode_out      = (mode == MODE_WAIT);
    assign osc_change_irq_out = irq;
    assign osc_stop_reset_out = reset_halt;                                      // [R10]
endmodule

// ===== clock_mode_osc_monitor_protect_chk.sv
/* assertions on the ports of the clock, mode and oscillator monitor block.
   assumes it is bound to every instance of clock_mode_osc_monitor_protect. */
`timescale 1ns/100ps
module clock_mode_chk (
    input wire logic                        sys_clk_in,
    input wire logic                        rst_in,
    input wire clock_mode_pkg::sw_write_t   sw_wr_in,
    input wire logic                        wait_instr_in,
    input wire logic                        hw_irq_in,
    input wire logic                        main_osc_alive_in,
    input wire clock_mode_pkg::clk_status_t clk_status_out,
    input wire logic                        stop_mode_out,
    input wire logic                        wait_mode_out,
    input wire logic                        osc_change_irq_out,
    input wire logic                        osc_stop_reset_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    logic clk_we;
    logic next_clk_we;
    logic acc;
    // shadow of the clock group write enable
    always_comb begin
        next_clk_we = clk_we;
        if (sw_wr_in.en && sw_wr_in.idx == 4'hf) begin
            next_clk_we = sw_wr_in.data[0];
        end
    end
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_we <= 1'b0;
        end else begin
            clk_we <= next_clk_we;
        end
    end
    assign acc = sw_wr_in.en && clk_we && sw_wr_in.idx < 4'h6;
    sequence s_flip;
        $past(main_osc_alive_in) != $past(main_osc_alive_in, 2);
    endsequence
    sequence s_stop_exit;
        !stop_mode_out && clk_status_out.cpu_div == 5'h08;
    endsequence
    stop_entry_a: assert property (acc && sw_wr_in.idx == 4'h1 && sw_wr_in.data[0]
        && !hw_irq_in |=> stop_mode_out) else $error("stop mode not entered");
    stop_exit_a: assert property (stop_mode_out && hw_irq_in |=> s_stop_exit)
        else $error("bad stop exit");
    wait_entry_a: assert property (wait_instr_in && !stop_mode_out && !wait_mode_out
        && !hw_irq_in && !sw_wr_in.en |=> wait_mode_out) else $error("wait not entered");
    wait_exit_a: assert property (wait_mode_out && hw_irq_in |=> !wait_mode_out)
        else $error("wait not left");
    div8_force_a: assert property (acc && sw_wr_in.idx == 4'h0 && sw_wr_in.data[5]
        |=> clk_status_out.cpu_div == 5'h08 && !clk_status_out.main_osc_run)
        else $error("main stop without div8");
    guard_hold_a: assert property (sw_wr_in.en && sw_wr_in.idx < 4'h6 && !clk_we
        && !stop_mode_out && !hw_irq_in && $stable(main_osc_alive_in)
        |=> $stable(clk_status_out)) else $error("guarded write took effect");
    irq_cause_a: assert property (osc_change_irq_out |-> s_flip)
        else $error("irq without oscillator change");
    irq_pulse_a: assert property (osc_change_irq_out |=> !osc_change_irq_out)
        else $error("irq repeated while detected");
    reset_hold_a: assert property (osc_stop_reset_out |=> osc_stop_reset_out)
        else $error("halt released");
    reset_cause_a: assert property ($rose(osc_stop_reset_out) |-> s_flip)
        else $error("halt without oscillator change");
endmodule
bind clock_mode_osc_monitor_protect clock_mode_chk i_chk (.sys_clk_in(sys_clk_in),
    .rst_in(rst_in), .sw_wr_in(sw_wr_in), .wait_instr_in(wait_instr_in),
    .hw_irq_in(hw_irq_in), .main_osc_alive_in(main_osc_alive_in),
    .clk_status_out(clk_status_out), .stop_mode_out(stop_mode_out),
    .wait_mode_out(wait_mode_out), .osc_change_irq_out(osc_change_irq_out),
    .osc_stop_reset_out(osc_stop_reset_out));

// ===== tb_clock_mode_osc_monitor_protect.sv
/* self-checking bench for the clock, mode and oscillator monitor block.
   assumes the checker is bound from its own file. */
`timescale 1ns/100ps
module tb_clock_mode_osc_monitor_protect;
    logic                        clk = 1'b0;
    logic                        rst = 1'b1;
    clock_mode_pkg::sw_write_t   sw = '0;
    logic [3:0]                  rd_idx = 4'h0;
    logic                        wait_i = 1'b0;
    logic                        irq_i = 1'b0;
    logic                        alive = 1'b1;
    logic [7:0]                  rd_data;
    clock_mode_pkg::clk_status_t st;
    logic                        stop_m;
    logic                        wait_m;
    logic                        oirq;
    logic                        orst;
    logic [7:0]                  v;
    int                          failures = 0;
    int                          checks = 0;
    always #2 clk = ~clk;
    clock_mode_osc_monitor_protect i_clock_mode_osc_monitor_protect (.sys_clk_in(clk),
        .rst_in(rst), .sw_wr_in(sw), .rd_idx_in(rd_idx), .wait_instr_in(wait_i),
        .hw_irq_in(irq_i), .main_osc_alive_in(alive), .rd_data_out(rd_data),
        .clk_status_out(st), .stop_mode_out(stop_m), .wait_mode_out(wait_m),
        .osc_change_irq_out(oirq), .osc_stop_reset_out(orst));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        sw = '{en: 1'b1, idx: i, data: d};
        tick(1);
        sw.en = 1'b0;
        // idle edge so the next write never re-raises en in this time step
        tick(1);
    endtask
    task automatic rd(input logic [3:0] i);
        rd_idx = i;
        tick(1);
        v = rd_data;
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic do_reset;
        rst = 1'b1;
        tick(10);
        rst = 1'b0;
    endtask
    task automatic t_guard;
        chk(8'(st.cpu_div), 8'h08, "div after reset");
        wr(4'h0, 8'h80);
        rd(4'h0);
        chk(v, 8'h40, "guarded write");
        chk(8'(st.cpu_src), 8'h00, "src after guarded write");
    endtask
    task automatic t_div;
        wr(4'hf, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wr(4'h1, {2'(k), 6'h00});
            wr(4'h0, 8'h00);
            chk(8'(st.cpu_div), 8'(1 << (k == 3 ? 4 : k)), "divider");
        end
        wr(4'h0, 8'h40);
        chk(8'(st.cpu_div), 8'h08, "div8 over hi:lo");
        wr(4'h1, 8'h00);
    endtask
    task automatic t_src;
        wr(4'h0, 8'h80);
        chk(8'(st.cpu_src), 8'h03, "sub source");
        wr(4'h0, 8'h00);
        wr(4'h2, 8'h02);
        chk(8'(st.cpu_src), 8'h02, "on-chip source");
        wr(4'h2, 8'h00);
        wr(4'h3, 8'h80);
        chk(8'(st.cpu_src), 8'h00, "pll on only");
        wr(4'h1, 8'h02);
        chk(8'(st.cpu_src), 8'h01, "pll source");
        wr(4'h3, 8'h00);
        chk(8'(st.cpu_src), 8'h00, "pll select only");
        wr(4'h1, 8'h00);
    endtask
    task automatic t_osc;
        wr(4'h0, 8'h10);
        chk(8'(st.sub_osc_run), 8'h01, "sub osc run");
        wr(4'h0, 8'h20);
        chk(8'(st.main_osc_run), 8'h00, "main osc stop");
        chk(8'(st.cpu_div), 8'h08, "forced div8");
        wr(4'h0, 8'h04);
        chk(8'(st.wait_periph_clk_stop), 8'h01, "wait periph stop set");
        wr(4'h0, 8'h00);
        chk(8'(st.main_osc_run), 8'h01, "main osc run");
    endtask
    task automatic t_modes;
        wr(4'h1, 8'h01);
        chk(8'(stop_m), 8'h01, "stop entry");
        irq_i = 1'b1;
        tick(1);
        irq_i = 1'b0;
        chk(8'(stop_m), 8'h00, "stop exit");
        chk(8'(st.cpu_div), 8'h08, "div8 on stop exit");
        chk(8'(st.wait_periph_clk_stop), 8'h00, "wait periph stop clear");
        wait_i = 1'b1;
        tick(1);
        wait_i = 1'b0;
        tick(2);
        chk(8'(wait_m), 8'h01, "wait entry");
        irq_i = 1'b1;
        tick(1);
        irq_i = 1'b0;
        chk(8'(wait_m), 8'h00, "wait exit");
    endtask
    task automatic t_prot;
        wr(4'hf, 8'h05);
        wr(4'hc, 8'haa);
        wr(4'hc, 8'h55);
        rd(4'hc);
        chk(v, 8'haa, "dir enable single shot");
        rd(4'hf);
        chk(v, 8'h01, "protect after writes");
        wr(4'hf, 8'h03);
        wr(4'h6, 8'h5a);
        wr(4'hf, 8'h01);
        wr(4'h6, 8'h11);
        rd(4'h6);
        chk(v, 8'h5a, "mode group guard");
    endtask
    task automatic osc_step(input logic a, input logic [7:0] exp);
        alive = a;
        tick(1);
        chk(8'(oirq), exp, "osc change irq");
        tick(1);
        chk(8'(oirq), 8'h00, "irq pulse end");
    endtask
    task automatic t_mon;
        wr(4'h2, 8'h80);
        osc_step(1'b0, 8'h00);
        osc_step(1'b1, 8'h00);
        wr(4'h2, 8'h81);
        osc_step(1'b0, 8'h01);
        rd(4'h2);
        chk(v, 8'h8f, "stop flags main source");
        chk(8'(st.cpu_src), 8'h02, "cpu on on-chip after stop");
        chk(8'(st.onchip_osc_run), 8'h01, "on-chip osc started");
        osc_step(1'b1, 8'h00);
        wr(4'h2, 8'h8b);
        osc_step(1'b0, 8'h01);
        wr(4'h2, 8'h8b);
        osc_step(1'b1, 8'h01);
        rd(4'h2);
        chk(v, 8'h87, "re-osc flags");
        wr(4'h2, 8'h80);
        wr(4'h3, 8'h80);
        wr(4'h1, 8'h02);
        wr(4'h2, 8'h81);
        osc_step(1'b0, 8'h01);
        rd(4'h2);
        chk(v, 8'h8d, "stop flags pll source");
        chk(8'(st.cpu_src), 8'h01, "pll source kept");
        wr(4'h2, 8'h80);
        wr(4'h0, 8'h80);
        wr(4'h2, 8'h81);
        osc_step(1'b1, 8'h01);
        wr(4'h2, 8'h81);
        osc_step(1'b0, 8'h01);
        chk(8'(st.cpu_src), 8'h03, "cpu stays on sub");
        chk(8'(st.periph_on_onchip), 8'h01, "peripherals on on-chip");
        chk(8'(st.onchip_osc_run), 8'h01, "on-chip osc for peripherals");
        alive = 1'b1;
        wr(4'h2, 8'h01);
        alive = 1'b0;
        tick(1);
        chk(8'(orst), 8'h01, "halt on stop");
        alive = 1'b1;
        tick(3);
        chk(8'(orst), 8'h01, "halt held");
        do_reset();
        chk(8'(orst), 8'h00, "halt released by reset");
    endtask
    initial begin
        #5000;
        failures++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        close_out();
    end
    initial begin
        do_reset();
        t_guard();
        t_div();
        t_src();
        t_osc();
        t_modes();
        t_prot();
        t_mon();
        close_out();
    end
endmodule
